// *** logic/serial_tx.v ***
// Serial 8b/10b transmitter: input register, encoder, shifter, outputs, bus.
`include "serial_tx_map.vh"

module serial_tx #(
    parameter WIDTH = 12,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  data_i,
    input  wire        special_char_select_i,
    input  wire        force_violation_i,
    input  wire [9:0]  bypass_bits_i,
    input  wire        load_now_n_i,
    input  wire        load_next_n_i,
    input  wire        optical_output_off_i,
    output wire        byte_ready_o,
    output reg         byte_write_clock_o,
    output reg         fifo_read_pulse_n_o,
    output reg         serial_line_1_o,
    output reg         serial_line_2_o,
    output reg         serial_line_3_o,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);

    // Data table for 5b/6b, given in its negative-disparity form abcdei.
    function [5:0] enc6;
        input [4:0] x;
        begin
            case (x)
                5'd0:  enc6 = 6'b100111;
                5'd1:  enc6 = 6'b011101;
                5'd2:  enc6 = 6'b101101;
                5'd3:  enc6 = 6'b110001;
                5'd4:  enc6 = 6'b110101;
                5'd5:  enc6 = 6'b101001;
                5'd6:  enc6 = 6'b011001;
                5'd7:  enc6 = 6'b111000;
                5'd8:  enc6 = 6'b111001;
                5'd9:  enc6 = 6'b100101;
                5'd10: enc6 = 6'b010101;
                5'd11: enc6 = 6'b110100;
                5'd12: enc6 = 6'b001101;
                5'd13: enc6 = 6'b101100;
                5'd14: enc6 = 6'b011100;
                5'd15: enc6 = 6'b010111;
                5'd16: enc6 = 6'b011011;
                5'd17: enc6 = 6'b100011;
                5'd18: enc6 = 6'b010011;
                5'd19: enc6 = 6'b110010;
                5'd20: enc6 = 6'b001011;
                5'd21: enc6 = 6'b101010;
                5'd22: enc6 = 6'b011010;
                5'd23: enc6 = 6'b111010;
                5'd24: enc6 = 6'b110011;
                5'd25: enc6 = 6'b100110;
                5'd26: enc6 = 6'b010110;
                5'd27: enc6 = 6'b110110;
                5'd28: enc6 = 6'b001110;
                5'd29: enc6 = 6'b101110;
                5'd30: enc6 = 6'b011110;
                default: enc6 = 6'b101011;
            endcase
        end
    endfunction

    // Data table for 3b/4b, negative-disparity form fghj, primary codes.
    function [3:0] enc4;
        input [2:0] y;
        begin
            case (y)
                3'd0:    enc4 = 4'b1011;
                3'd1:    enc4 = 4'b1001;
                3'd2:    enc4 = 4'b0101;
                3'd3:    enc4 = 4'b1100;
                3'd4:    enc4 = 4'b1101;
                3'd5:    enc4 = 4'b1010;
                3'd6:    enc4 = 4'b0110;
                default: enc4 = 4'b1110;
            endcase
        end
    endfunction

    // Trailer of K28.y when the symbol starts at negative disparity.
    function [3:0] k28_four;
        input [2:0] y;
        begin
            case (y)
                3'd0:    k28_four = 4'b0100;
                3'd1:    k28_four = 4'b1001;
                3'd2:    k28_four = 4'b0101;
                3'd3:    k28_four = 4'b0011;
                3'd4:    k28_four = 4'b0010;
                3'd5:    k28_four = 4'b1010;
                3'd6:    k28_four = 4'b0110;
                default: k28_four = 4'b1000;
            endcase
        end
    endfunction

    function [2:0] ones6;
        input [5:0] v;
        begin
            ones6 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
                  + {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
        end
    endfunction

    reg  [3:0]       bit_cnt;
    reg  [9:0]       shifter;
    reg              disparity, load_pending;
    reg  [8:0]       lfsr;
    reg  [1:0]       ctrl;
    reg              off_meta, off_sync;
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr, rd_ptr;
    reg  [AW:0]      count;
    reg  [9:0]       next_code;
    reg              next_disparity;
    reg  [WIDTH-1:0] entry;
    reg  [5:0]       six_rdn, six;
    reg  [3:0]       four_rdn, four;
    reg              rd6, six_bal, four_bal, use_alt;
    wire             byte_edge, capture;
    wire             full, empty;
    wire             push, pop, wb_req;
    wire             bypass, self_test;
    wire [4:0]       x;
    wire [2:0]       y;
    wire [3:0]       next_bit_cnt;

    assign bypass       = ctrl[`CTRL_BYPASS];
    assign self_test    = ctrl[`CTRL_SELF_TEST];
    // The byte edge is a fixed count of bit clocks; no pin level moves it.
    assign byte_edge    = (bit_cnt == `LAST_BIT);
    assign next_bit_cnt = byte_edge ? 4'd0 : bit_cnt + 4'd1;
    assign capture      = byte_edge & (~load_now_n_i | load_pending);
    assign full         = (count == DEPTH[AW:0]);
    assign empty        = (count == {(AW+1){1'b0}});
    assign byte_ready_o = ~full;
    // A byte offered while both entries are taken is refused, not overwritten.
    assign push         = capture & ~full & ~self_test;
    assign pop          = byte_edge & ~empty & ~self_test;
    assign wb_req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Clock and byte counter; clk_i stands for the crystal-locked bit clock.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bit_cnt             <= 4'd0;
            byte_write_clock_o  <= 1'b1;
            fifo_read_pulse_n_o <= 1'b0;
        end
        else
        begin
            bit_cnt             <= next_bit_cnt;
            byte_write_clock_o  <= (next_bit_cnt < `PULSE_BITS);
            // Width is a fixed count of bit clocks, so no duty cycle leaks in.
            fifo_read_pulse_n_o <= ~(next_bit_cnt < `PULSE_BITS);
        end
    end

    // Input register front: load-next arms a capture at the next byte edge.
    always @(posedge clk_i)
    begin
        if (rst_i)
            load_pending <= 1'b0;
        else if (byte_edge)
            load_pending <= ~load_next_n_i;
    end

    always @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= {force_violation_i, special_char_select_i,
                            bypass ? bypass_bits_i : {2'b00, data_i}};
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (push & ~pop)
                count <= count + {{AW{1'b0}}, 1'b1};
            else if (pop & ~push)
                count <= count - {{AW{1'b0}}, 1'b1};
        end
    end

    // Pattern source: x^9 + x^5 + 1 walks all 511 nonzero states.
    always @(posedge clk_i)
    begin
        if (rst_i | ~self_test)
            lfsr <= `LFSR_SEED;
        else if (byte_edge)
            lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
    end

    // Select what the next byte time carries.
    always @*
    begin
        if (self_test)
            entry = {lfsr == `LFSR_ALL_ONES, lfsr[8], 2'b00, lfsr[7:0]};
        else if (empty)
            entry = {1'b0, 1'b1, 2'b00, `COMMA_BYTE};
        else
            entry = mem[rd_ptr];
    end

    assign x = entry[4:0];
    assign y = entry[7:5];

    // Encoder; code bits are held a..j from bit 9 down to bit 0.
    always @*
    begin
        six_rdn  = (entry[10] && x == 5'd28) ? `K28_SIX_RDN : enc6(x);
        six_bal  = (ones6(six_rdn) == 3'd3);
        if (!disparity)
            six = six_rdn;
        else if (!six_bal)
            six = ~six_rdn;
        else if (six_rdn == 6'b111000)
            six = 6'b000111;
        else
            six = six_rdn;
        rd6      = disparity ^ ~six_bal;
        use_alt  = (y == 3'd7) && (entry[10] ||
                   (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
                   (rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
        four_rdn = use_alt ? 4'b0111 : enc4(y);
        four_bal = (ones6({2'b00, four_rdn}) == 3'd2);
        if (entry[10] && x == 5'd28)
            four = disparity ? ~k28_four(y) : k28_four(y);
        else if (rd6 && (!four_bal || y == 3'd3))
            four = ~four_rdn;
        else
            four = four_rdn;
        next_code      = {six, four};
        next_disparity = rd6 ^ ~four_bal;
        if (entry[10] && x == 5'd28)
            next_disparity = rd6;
        if (bypass && !empty && !self_test)
        begin
            next_code      = entry[9:0];
            next_disparity = disparity;
        end
        else if (entry[11])
        begin
            next_code      = disparity ? ~`VIOLATION_RDN : `VIOLATION_RDN;
            next_disparity = disparity;
        end
    end

    // Shifter: parallel load at the byte edge, bit a leaves first.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shifter   <= 10'h000;
            disparity <= 1'b0;
        end
        else if (byte_edge)
        begin
            shifter   <= next_code;
            disparity <= next_disparity;
        end
        else
            shifter   <= {shifter[8:0], 1'b0};
    end

    // Output-off is a free pin; it is synchronised but never byte aligned.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            off_meta        <= 1'b0;
            off_sync        <= 1'b0;
            serial_line_1_o <= 1'b0;
            serial_line_2_o <= 1'b0;
            serial_line_3_o <= 1'b0;
        end
        else
        begin
            off_meta        <= optical_output_off_i;
            off_sync        <= off_meta;
            serial_line_1_o <= shifter[9] & ~off_sync;
            serial_line_2_o <= shifter[9] & ~off_sync;
            serial_line_3_o <= shifter[9];
        end
    end

    // Wishbone slave: one wait state, unmapped reads return zero.
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl     <= `CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ADR_CTRL)
                ctrl <= wb_dat_i[1:0];
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `ADR_CTRL:    wb_dat_o <= {30'h00000000, ctrl};
                    `ADR_STATUS:  wb_dat_o <= {28'h0000000, load_pending,
                                               count, disparity};
                    `ADR_PATTERN: wb_dat_o <= {23'h000000, lfsr};
                    default:      wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // serial_tx

// *** logic/serial_tx_map.vh ***
// Constants, offsets and timing counts of the serial 8b/10b transmitter.
`ifndef SERIAL_TX_MAP_VH
`define SERIAL_TX_MAP_VH

`define BITS_PER_BYTE     4'd10
`define LAST_BIT          4'd9
`define PULSE_BITS        4'd5

`define ADR_CTRL          8'h00
`define ADR_STATUS        8'h04
`define ADR_PATTERN       8'h08

`define CTRL_BYPASS       0
`define CTRL_SELF_TEST    1
`define CTRL_RESET        2'b00

`define LFSR_SEED         9'h001
`define LFSR_ALL_ONES     9'h1ff
`define COMMA_BYTE        8'hbc
`define K28_SIX_RDN       6'b001111
`define VIOLATION_RDN     10'b1001111000

`endif

// *** tb/serial_tx_props.sv ***
// Concurrent checks on the port behaviour of the serial transmitter.
module serial_tx_props (
    input logic clk_i,
    input logic rst_i,
    input logic optical_output_off_i,
    input logic byte_write_clock_o,
    input logic fifo_read_pulse_n_o,
    input logic serial_line_1_o,
    input logic serial_line_2_o,
    input logic serial_line_3_o,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // The output-off pin is resynchronised, so judge it after four samples.
    logic [3:0] offh;
    always @(posedge clk_i)
        offh <= {offh[2:0], optical_output_off_i};
    a_off_forces_low: assert property (offh == 4'hf |->
        !serial_line_1_o && !serial_line_2_o) else $error("lines not off");
    a_lines_same_stream: assert property (offh == 4'h0 |->
        serial_line_1_o == serial_line_3_o &&
        serial_line_2_o == serial_line_3_o) else $error("lines differ");
    a_off_acts_fast: assert property ($rose(optical_output_off_i)
        |-> ##[1:4] (!serial_line_1_o && !serial_line_2_o))
        else $error("output-off too slow");
    a_byte_ten_bits: assert property ($rose(byte_write_clock_o)
        |-> byte_write_clock_o[*5] ##1 !byte_write_clock_o[*5]
        ##1 byte_write_clock_o) else $error("byte time not ten bits");
    a_read_pulse_phase: assert property (
        fifo_read_pulse_n_o != byte_write_clock_o)
        else $error("read pulse out of phase");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_caused: assert property (wb_ack_o |->
        $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
endmodule // serial_tx_props

bind serial_tx serial_tx_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .optical_output_off_i(optical_output_off_i),
    .byte_write_clock_o(byte_write_clock_o),
    .fifo_read_pulse_n_o(fifo_read_pulse_n_o),
    .serial_line_1_o(serial_line_1_o), .serial_line_2_o(serial_line_2_o),
    .serial_line_3_o(serial_line_3_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// *** tb/host_fifo_model.sv ***
// Host byte source presenting one queued byte per byte time.
module host_fifo_model (
    input  wire logic       clk_i,
    input  wire logic       byte_clk_i,
    input  wire logic       ready_i,
    output logic [7:0] data_o,
    output logic       special_o,
    output logic       violation_o,
    output logic [9:0] bypass_o,
    output logic       now_n_o,
    output logic       next_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [20:0] q[$];
    logic [20:0] e;
    logic        pb = 1'b1;
    logic        armed = 1'b0;
    logic        nw;
    logic        nx;
    initial
    begin
        {violation_o, special_o, data_o, bypass_o} <= 20'h0;
        now_n_o <= 1'b1;
        next_n_o <= 1'b1;
    end
    // Changing as the byte clock rises gives nine bit times of setup.
    always @(posedge clk_i)
    begin
        nw = 1'b1;
        nx = 1'b1;
        if (byte_clk_i && !pb)
        begin
            if (armed)
            begin
                {violation_o, special_o, data_o, bypass_o} <= e[19:0];
                armed = 1'b0;
            end
            else if (q.size() != 0 && ready_i)
            begin
                e = q.pop_front();
                armed = e[20];
                nx = !e[20];
                nw = e[20];
                // Garbage stands while only the next-load is armed.
                {violation_o, special_o, data_o, bypass_o} <=
                    e[20] ? ~e[19:0] : e[19:0];
            end
            else
                {data_o, bypass_o} <= ~{data_o, bypass_o};
            now_n_o <= nw;
            next_n_o <= nx;
        end
        pb = byte_clk_i;
    end
endmodule // host_fifo_model

// *** tb/serial_tx_tb.sv ***
// Self-checking bench of the serial transmitter against a symbol model.
module serial_tx_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        off = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack, ready, bclk, rpn, l1, l2, l3, sc, viol, nown, nextn;
    logic [7:0]  data;
    logic [9:0]  bypass, sh, b;
    logic        pb = 1'b1;
    logic        watch = 1'b1;
    logic [10:0] exp_q[$];
    int          n_mismatch = 0, check_count = 0, nb = 0, seed = 12553;

    always #5 clk_i = ~clk_i;

    serial_tx dut (.clk_i(clk_i), .rst_i(rst_i), .data_i(data),
        .special_char_select_i(sc), .force_violation_i(viol),
        .bypass_bits_i(bypass), .load_now_n_i(nown),
        .load_next_n_i(nextn), .optical_output_off_i(off),
        .byte_ready_o(ready), .byte_write_clock_o(bclk),
        .fifo_read_pulse_n_o(rpn), .serial_line_1_o(l1),
        .serial_line_2_o(l2), .serial_line_3_o(l3), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

    host_fifo_model host (.clk_i(clk_i), .byte_clk_i(bclk),
        .ready_i(ready), .data_o(data), .special_o(sc),
        .violation_o(viol), .bypass_o(bypass), .now_n_o(nown),
        .next_n_o(nextn));

    task automatic results;
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                      output logic [31:0] r);
        int t;
        t = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk_i);
        while (ack !== 1'b1 && t < 50)
        begin
            @(posedge clk_i);
            t++;
        end
        chk("ack", 32'h1, 32'(ack));
        r = rdat;
        cyc <= 1'b0;
        sel <= 4'h0;
        @(posedge clk_i);
    endtask

    task automatic put(logic n, logic v, logic s, logic [7:0] d,
                       logic [9:0] bb, logic any, logic [9:0] p);
        host.q.push_back({n, v, s, d, bb});
        exp_q.push_back({any, p});
    endtask

    task automatic drain;
        int t;
        t = 0;
        while (exp_q.size() != 0 && t < 600)
        begin
            @(posedge clk_i);
            t++;
        end
        chk("left", 32'h0, 32'(exp_q.size()));
        chk("ready", 32'h1, 32'(ready));
    endtask

    // A symbol is complete when the byte clock rises; commas are fill.
    always @(posedge clk_i)
    begin
        logic [10:0] e;
        sh = {sh[8:0], l3};
        if (bclk && !pb && !rst_i && watch)
        begin
            nb++;
            if (nb == 2 || nb == 3)
                chk("idle", 32'(nb == 2 ? 10'h0fa : 10'h305), 32'(sh));
            else if (nb > 3 && sh !== 10'h0fa && sh !== 10'h305)
            begin
                e = exp_q.size() != 0 ? exp_q.pop_front() : 11'h0fa;
                if (e[10] && sh === ~e[9:0])
                    e[9:0] = ~e[9:0];
                chk("symbol", 32'(e[9:0]), 32'(sh));
            end
        end
        pb = bclk;
    end

    initial
    begin
        #200000;
        n_mismatch++;
        results();
    end

    initial
    begin
        logic [31:0] r, p0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        wb(0, 8'h08, 0, r);
        chk("pattern", 32'h1, r);
        wb(1, 8'h00, 32'h1, r);
        wb(1, 8'hfc, 32'h2, r);
        wb(0, 8'h00, 0, r);
        chk("ctrl", 32'h1, r);
        wb(0, 8'hfc, 0, r);
        chk("unmapped", 32'h0, r);
        for (int i = 0; i < 12; i++)
        begin
            b = 10'($random(seed));
            b[0] = ~b[9];
            put(i % 3 == 2, 0, 0, 8'($random(seed)), b, 0, b);
        end
        repeat (35) @(posedge clk_i);
        off <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk("line1 off", 32'h0, 32'(l1));
        off <= 1'b0;
        drain();
        wb(0, 8'h04, 0, r);
        chk("status", 32'h0, r & 32'hfffffffe);
        wb(1, 8'h00, 32'h0, r);
        put(0, 0, 0, 8'hb5, 0, 0, 10'h2aa);
        put(1, 1, 0, 8'h00, 0, 1, 10'h278);
        put(0, 0, 1, 8'h3c, 0, 1, 10'h0f9);
        put(0, 0, 0, 8'hb5, 0, 0, 10'h2aa);
        drain();
        watch = 1'b0;
        wb(1, 8'h00, 32'h2, r);
        @(posedge bclk);
        wb(0, 8'h08, 0, p0);
        @(posedge bclk);
        wb(0, 8'h08, 0, r);
        chk("lfsr step", 32'({p0[7:0], p0[8] ^ p0[4]}), r);
        repeat (510) @(posedge bclk);
        wb(0, 8'h08, 0, r);
        chk("lfsr period", p0, r);
        wb(1, 8'h00, 32'h0, r);
        repeat (40) @(posedge clk_i);
        watch = 1'b1;
        repeat (40) @(posedge clk_i);
        results();
    end
endmodule // serial_tx_tb
